// >>> rrr_pkg.sv
// Package for the result register readout block: widths, counts and carried structs.
// Assumes a single 100 MHz system clock domain with synchronous active-high reset.
package rrr_pkg;
   localparam int unsigned NUM_REGS = 4;
   localparam int unsigned DATA_W = 14;
   localparam int unsigned PTR_W = 2;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned CONV_CLKS = 16;
   localparam int unsigned XFER_CLK = 14;
   localparam logic [PTR_W-1:0] PTR_FIRST = 2'h0;
   localparam logic [DATA_W-1:0] CODE_MAX = 14'h1fff;
   localparam logic [DATA_W-1:0] CODE_MIN = 14'h2000;
   typedef logic [DATA_W-1:0] rrr_code_t;
   typedef struct packed {
      logic first;
      rrr_code_t code;
   } rrr_result_s;
   typedef enum logic [1:0] {
      RRR_IDLE,
      RRR_CONV,
      RRR_XFER
   } rrr_state_e;
endpackage : rrr_pkg

// >>> rrr_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and synchronous active-high reset.
module rrr_fifo #(
   parameter int unsigned WIDTH = 15,
   parameter int unsigned DEPTH = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : rrr_fifo

// >>> rrr_readout.sv
// Result register readout: conversion sequencer timing, four result registers and host port.
// Assumes results arrive as signed codes, one per conversion, and host pins synchronous.
module rrr_readout #(
   parameter int unsigned NUM_REGS = rrr_pkg::NUM_REGS,
   parameter int unsigned DATA_W = rrr_pkg::DATA_W,
   parameter int unsigned CONV_CLKS = rrr_pkg::CONV_CLKS,
   parameter int unsigned XFER_CLK = rrr_pkg::XFER_CLK
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic conv_clk_en,
   input wire logic start,
   input wire logic [NUM_REGS-1:0] chan_sel,
   input wire logic [DATA_W-1:0] sample_code,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic cs_n,
   input wire logic rd_n,
   output logic [DATA_W-1:0] result_bus_o,
   output logic result_bus_oe_n,
   output logic busy,
   output logic eoc_n,
   output logic first_result_flag
);
   localparam int unsigned PW = rrr_pkg::PTR_W;
   localparam int unsigned CW = $clog2(CONV_CLKS + 1);
   localparam int unsigned NW = $clog2(NUM_REGS + 1);

   rrr_pkg::rrr_state_e state_r;
   logic [CW-1:0] clk_cnt_r;
   logic [NW-1:0] todo_r;
   logic [NW-1:0] done_r;
   logic [PW-1:0] ptr_r;
   logic pend_r;
   logic rd_n_r;
   logic [DATA_W-1:0] regs_r [NUM_REGS];
   logic [DATA_W-1:0] bus_r;
   logic eoc_r;
   logic flag_r;
   logic rd_rise;
   logic xfer;
   logic next_ready;
   logic is_last;
   logic [PW-1:0] ptr_inc;
   logic [NW-1:0] ptr_ext;
   logic [NW-1:0] avail;
   rrr_pkg::rrr_result_s fifo_out;
   logic fifo_valid;
   logic fifo_ready;

   // Buffered sample path; the converter core stalls on sample_ready.
   rrr_fifo #(
      .WIDTH($bits(rrr_pkg::rrr_result_s)),
      .DEPTH(rrr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_data({1'b0, sample_code}),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready)
   );

   // Transfer happens on the 14th conversion clock, only when a sample waits.
   assign xfer = (state_r == rrr_pkg::RRR_CONV) && conv_clk_en
      && (clk_cnt_r == CW'(XFER_CLK - 1)) && fifo_valid;
   assign fifo_ready = xfer;
   assign rd_rise = !rd_n_r && rd_n;
   assign ptr_inc = ptr_r + 1'b1;
   // Widened index so the last register is not mistaken for a wrap to the first.
   assign ptr_ext = NW'(ptr_r) + NW'(1);
   // A result landing in the same cycle as a read edge already counts as available.
   assign avail = done_r + NW'(xfer);
   assign is_last = (ptr_ext >= avail);
   assign next_ready = (ptr_ext < avail);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= rrr_pkg::RRR_IDLE;
         clk_cnt_r <= '0;
         todo_r <= '0;
      end else begin
         case (state_r)
            rrr_pkg::RRR_IDLE: begin
               if (start && (chan_sel != '0)) begin
                  todo_r <= NW'($countones(chan_sel));
                  clk_cnt_r <= '0;
                  state_r <= rrr_pkg::RRR_CONV;
               end
            end
            rrr_pkg::RRR_CONV: begin
               if (conv_clk_en) begin
                  if (clk_cnt_r == CW'(XFER_CLK - 1) && !fifo_valid) begin
                     clk_cnt_r <= clk_cnt_r;
                  end else if (clk_cnt_r == CW'(CONV_CLKS - 1)) begin
                     clk_cnt_r <= '0;
                     todo_r <= todo_r - 1'b1;
                     if (todo_r == NW'(1)) begin
                        state_r <= rrr_pkg::RRR_IDLE;
                     end
                  end else begin
                     clk_cnt_r <= clk_cnt_r + 1'b1;
                  end
               end
            end
            default: begin
               state_r <= rrr_pkg::RRR_IDLE;
            end
         endcase
      end
   end

   // Busy stays high through every selected conversion.
   assign busy = (state_r != rrr_pkg::RRR_IDLE);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_r <= '0;
      end else if (state_r == rrr_pkg::RRR_IDLE && start && (chan_sel != '0)) begin
         done_r <= '0;
      end else if (xfer) begin
         done_r <= done_r + 1'b1;
      end
   end

   // Results land in consecutive registers in conversion order.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= '0;
         end
      end else if (xfer) begin
         regs_r[done_r[PW-1:0]] <= fifo_out.code;
      end
   end

   // End pulse is low for one conversion clock after each transfer.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         eoc_r <= 1'b0;
      end else if (xfer) begin
         eoc_r <= 1'b1;
      end else if (conv_clk_en) begin
         eoc_r <= 1'b0;
      end
   end
   assign eoc_n = !eoc_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_n_r <= 1'b1;
      end else begin
         rd_n_r <= rd_n;
      end
   end

   // Register pointer: reset on first transfer, advance on reads or deferred at transfer.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ptr_r <= rrr_pkg::PTR_FIRST;
         pend_r <= 1'b0;
      end else if (xfer && done_r == '0) begin
         ptr_r <= rrr_pkg::PTR_FIRST;
         pend_r <= 1'b0;
      end else if (xfer && pend_r) begin
         ptr_r <= ptr_inc;
         pend_r <= 1'b0;
      end else if (rd_rise && !cs_n) begin
         if (next_ready) begin
            ptr_r <= ptr_inc;
         end else if (busy) begin
            pend_r <= 1'b1;
         end else if (is_last) begin
            ptr_r <= rrr_pkg::PTR_FIRST;
         end
      end
   end

   // Flag follows the pointer at register 0; its power-up level is left high.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flag_r <= 1'b1;
      end else if (xfer && done_r == '0) begin
         flag_r <= 1'b1;
      end else if (xfer && pend_r) begin
         flag_r <= 1'b0;
      end else if (rd_rise && !cs_n && (next_ready || (!busy && is_last))) begin
         flag_r <= !next_ready;
      end
   end
   assign first_result_flag = flag_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_r <= '0;
      end else begin
         bus_r <= regs_r[ptr_r];
      end
   end
   assign result_bus_o = bus_r;
   assign result_bus_oe_n = !(!cs_n && !rd_n);
endmodule : rrr_readout

// >>> rrr_host_model.sv
// Host model that reads the result bus with chip select and read strobe.
// Assumes the bench calls rd at a falling edge of sys_clk.
module rrr_host_model (
   input wire logic sys_clk,
   input wire rrr_pkg::rrr_code_t bus,
   input wire logic bus_oe_n,
   output logic cs_n,
   output logic rd_n
);
   initial begin
      cs_n = 1'h1;
      rd_n = 1'h1;
   end
   task automatic rd(output rrr_pkg::rrr_code_t d);
      cs_n = 1'h0;
      rd_n = 1'h0;
      repeat (3) @(negedge sys_clk);
      d = bus_oe_n ? ~bus : bus;
      rd_n = 1'h1;
      @(negedge sys_clk);
      cs_n = 1'h1;
      repeat (2) @(negedge sys_clk);
   endtask : rd
endmodule : rrr_host_model

// >>> rrr_readout_properties.sv
// Checker for the result register readout ports.
// Assumes one clock and synchronous active-high reset.
module rrr_readout_properties #(
   parameter int unsigned NUM_REGS = 4,
   parameter int unsigned DATA_W = 14
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic conv_clk_en,
   input wire logic start,
   input wire logic [NUM_REGS-1:0] chan_sel,
   input wire logic [DATA_W-1:0] sample_code,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic [DATA_W-1:0] result_bus_o,
   input wire logic result_bus_oe_n,
   input wire logic busy,
   input wire logic eoc_n,
   input wire logic first_result_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_oe; result_bus_oe_n == (cs_n | rd_n); endproperty
   a_oe: assert property (p_oe) else $error("bus enable wrong");
   property p_rst; $past(rst) |-> !busy && eoc_n && first_result_flag; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_start; start && !busy && chan_sel != '0 |=> busy; endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_eoc; !eoc_n |=> eoc_n == $past(conv_clk_en); endproperty
   a_eoc: assert property (p_eoc) else $error("end pulse length");
   property p_eoc_busy; !eoc_n |-> busy; endproperty
   a_eoc_busy: assert property (p_eoc_busy) else $error("end pulse idle");
   property p_end; $fell(busy) |-> eoc_n && $past(eoc_n); endproperty
   a_end: assert property (p_end) else $error("busy fell early");
   property p_rise; $rose(first_result_flag) |-> $fell(eoc_n) || !busy; endproperty
   a_rise: assert property (p_rise) else $error("flag rose late");
   property p_idle;
      !busy && cs_n && $past(cs_n) && $past(cs_n, 2) |=> $stable(first_result_flag);
   endproperty
   a_idle: assert property (p_idle) else $error("pointer moved idle");
   cover property ($fell(busy));
   cover property ($rose(first_result_flag) && !busy);
   cover property (!result_bus_oe_n && busy);
endmodule : rrr_readout_properties
bind rrr_readout rrr_readout_properties #(
   .NUM_REGS(NUM_REGS),
   .DATA_W(DATA_W)
) chk (
   .sys_clk(sys_clk),
   .rst(rst),
   .conv_clk_en(conv_clk_en),
   .start(start),
   .chan_sel(chan_sel),
   .sample_code(sample_code),
   .sample_valid(sample_valid),
   .sample_ready(sample_ready),
   .cs_n(cs_n),
   .rd_n(rd_n),
   .result_bus_o(result_bus_o),
   .result_bus_oe_n(result_bus_oe_n),
   .busy(busy),
   .eoc_n(eoc_n),
   .first_result_flag(first_result_flag)
);

// >>> rrr_readout_bench.sv
// Self-checking bench for the result register readout.
// Assumes the host model drives the read port and the bench the converter side.
module rrr_readout_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, start, sample_valid, sample_ready, cs_n, rd_n;
   logic busy, eoc_n, first_result_flag, result_bus_oe_n;
   logic conv_clk_en = 1'h0;
   logic [3:0] chan_sel, s;
   rrr_pkg::rrr_code_t sample_code, result_bus_o, d;
   rrr_pkg::rrr_code_t exp_q[4];
   int n_fail = 0, num_checks = 0, seed = 32'h0000_9361, n, cyc = 0;
   rrr_readout uut (
      .sys_clk(sys_clk),
      .rst(rst),
      .conv_clk_en(conv_clk_en),
      .start(start),
      .chan_sel(chan_sel),
      .sample_code(sample_code),
      .sample_valid(sample_valid),
      .sample_ready(sample_ready),
      .cs_n(cs_n),
      .rd_n(rd_n),
      .result_bus_o(result_bus_o),
      .result_bus_oe_n(result_bus_oe_n),
      .busy(busy),
      .eoc_n(eoc_n),
      .first_result_flag(first_result_flag)
   );
   rrr_host_model host (.sys_clk(sys_clk), .bus(result_bus_o), .bus_oe_n(result_bus_oe_n),
      .cs_n(cs_n), .rd_n(rd_n));
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      cyc <= cyc + 1;
      conv_clk_en <= (cyc % 4 == 0);
   end
   task automatic stop_test;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic cmp_d(input rrr_pkg::rrr_code_t g, input rrr_pkg::rrr_code_t e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %0t data %h want %h", $time, g, e);
      end
   endtask : cmp_d
   task automatic cmp_b(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %0t flag %b want %b", $time, g, e);
      end
   endtask : cmp_b
   function automatic rrr_pkg::rrr_code_t code_for(input int i);
      return (i == 0) ? rrr_pkg::CODE_MAX : (i == 1) ? rrr_pkg::CODE_MIN : 14'($random(seed));
   endfunction : code_for
   task automatic seq(input logic [3:0] sel);
      n = $countones(sel);
      for (int i = 0; i < n; i++) begin
         exp_q[i] = code_for(i);
         sample_code = exp_q[i];
         sample_valid = 1'h1;
         while (sample_ready !== 1'h1) @(negedge sys_clk);
         @(negedge sys_clk);
      end
      sample_valid = 1'h0;
      cmp_b(sample_ready, 1'(n < rrr_pkg::FIFO_DEPTH));
      chan_sel = sel;
      start = 1'h1;
      @(negedge sys_clk);
      start = 1'h0;
      cmp_b(busy, 1'h1);
   endtask : seq
   task automatic wait_for(input bit eoc);
      for (int k = 0; k < 2000 && (eoc ? eoc_n : busy) !== 1'h0; k++) @(negedge sys_clk);
      cmp_b(eoc ? eoc_n : busy, 1'h0);
   endtask : wait_for
   task automatic read_after;
      wait_for(1'b0);
      cmp_b(first_result_flag, 1'h1);
      for (int i = 0; i < 2 * n; i++) begin
         host.rd(d);
         cmp_d(d, exp_q[i % n]);
         cmp_b(first_result_flag, 1'((i + 1) % n == 0));
      end
      cmp_b(first_result_flag, 1'h1);
   endtask : read_after
   initial begin
      rst = 1'h1;
      start = 1'h0;
      chan_sel = 4'h0;
      sample_code = 14'h0000;
      sample_valid = 1'h0;
      repeat (6) @(negedge sys_clk);
      rst = 1'h0;
      cmp_b(result_bus_oe_n, 1'h1);
      cmp_b(sample_ready, 1'h1);
      seq(4'hf);
      wait_for(1'b1);
      cmp_b(first_result_flag, 1'h1);
      host.rd(d);
      cmp_d(d, exp_q[0]);
      host.rd(d);
      cmp_d(d, exp_q[0]);
      wait_for(1'b1);
      cmp_b(first_result_flag, 1'h0);
      host.rd(d);
      cmp_d(d, exp_q[1]);
      wait_for(1'b0);
      seq(4'h5);
      read_after;
      for (int t = 0; t < 6; t++) begin
         s = 4'($random(seed));
         seq(s == 4'h0 ? 4'h8 : s);
         read_after;
      end
      stop_test;
   end
   initial begin
      #300000;
      n_fail++;
      stop_test;
   end
endmodule : rrr_readout_bench
